// [shared/cbf_pkg.sv]
// Shared types and constants for the card bus flow-control block.
// Assumes one 100 MHz clock and a synchronous active-high reset.
package cbf_pkg;

  // Bus modes, decoded from the mode-select pin and configuration
  typedef enum logic [2:0] {
    MODE_MEM = 3'b001,
    MODE_IO  = 3'b010,
    MODE_IDE = 3'b100
  } cbf_mode_t;

  // Ultra DMA sub-state
  typedef enum logic [2:0] {
    UDMA_IDLE  = 3'b001,
    UDMA_WRITE = 3'b010,
    UDMA_READ  = 3'b100
  } cbf_udma_t;

  localparam int DATA_W = 16;

  // Clock period and reset initialization time
  localparam int CLK_PERIOD_NS  = 10;
  localparam int INIT_TIME_NS   = 1000;
  localparam int INIT_CYCLES    = (INIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Strobe half period in clocks
  localparam int STROBE_HALF_CYC = 2;

  // Reset values of the pin outputs (active-low lines idle high)
  localparam logic WAIT_RST   = 1'b1;
  localparam logic WP_RST     = 1'b1;
  localparam logic IOIS16_RST = 1'b1;
  localparam logic DMARDY_RST = 1'b1;
  localparam logic STROBE_RST = 1'b0;

  // One data word with its valid tag
  typedef struct packed {
    logic              valid;
    logic [DATA_W-1:0] data;
  } cbf_word_t;

endpackage

// [rtl/cbf_skid_buf.sv]
// Two-entry buffer with valid/ready on both sides.
// Assumes source and sink on the same clock as the buffer.
module cbf_skid_buf #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 2
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             srst,
  // Fill side
  input  wire logic             inValid,
  input  wire logic [WIDTH-1:0] inData,
  output logic                  inReady,
  // Drain side
  output logic                  outValid,
  output logic [WIDTH-1:0]      outData,
  input  wire logic             outReady
);

  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0]    wrPtr_r, wrPtr_nxt;
  logic [PW-1:0]    rdPtr_r, rdPtr_nxt;
  logic [PW:0]      count_r, count_nxt;
  logic [PW:0]      kept;
  logic             outValid_nxt;
  logic [WIDTH-1:0] outData_nxt;
  logic             doWr;
  logic             doRd;

  // Handshakes, pointer updates and the registered head word
  always_comb begin
    inReady      = (count_r != (PW+1)'(DEPTH));
    doWr         = inValid && inReady;
    doRd         = outValid && outReady;
    kept         = count_r - (PW+1)'(doRd);
    wrPtr_nxt    = doWr ? ((wrPtr_r == PW'(DEPTH-1)) ? '0 : wrPtr_r + 1'b1) : wrPtr_r;
    rdPtr_nxt    = doRd ? ((rdPtr_r == PW'(DEPTH-1)) ? '0 : rdPtr_r + 1'b1) : rdPtr_r;
    count_nxt    = kept + (PW+1)'(doWr);
    outValid_nxt = (count_nxt != '0);
    // Empty after the pop: the head is the word arriving now
    outData_nxt  = (kept == '0) ? inData : mem[rdPtr_nxt];
  end

  // Register pointers, head word and storage
  always_ff @(posedge clk) begin
    if (srst) begin
      wrPtr_r  <= '0;
      rdPtr_r  <= '0;
      count_r  <= '0;
      outValid <= 1'b0;
      outData  <= '0;
    end else begin
      wrPtr_r  <= wrPtr_nxt;
      rdPtr_r  <= rdPtr_nxt;
      count_r  <= count_nxt;
      outValid <= outValid_nxt;
      outData  <= outData_nxt;
    end
    if (doWr) begin
      mem[wrPtr_r] <= inData;
    end
  end

endmodule

// [rtl/cbf_flow_ctrl.sv]
// Card-side flow control and qualifier pins of the parallel host bus.
// Assumes pin inputs are asynchronous; core signals share clk.
module cbf_flow_ctrl #(
  parameter int DATA_W      = cbf_pkg::DATA_W,
  parameter int INIT_CYCLES = cbf_pkg::INIT_CYCLES
) (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              srst,
  // Host pins (asynchronous)
  input  wire logic              modeSelN,
  input  wire logic              ioConfigured,
  input  wire logic              cycleActiveN,
  input  wire logic              writeStrobeN,
  input  wire logic              hostStrobe,
  input  wire logic              regSelN,
  input  wire logic [DATA_W-1:0] hostData,
  // Core status (same clock)
  input  wire logic              coreReady,
  input  wire logic              port16,
  input  wire logic              wordXfer,
  input  wire logic              udmaWrite,
  input  wire logic              udmaRead,
  // Ultra DMA write data to core
  output logic                   dinValid,
  output logic [DATA_W-1:0]      dinData,
  input  wire logic              dinReady,
  // Ultra DMA read data from core
  input  wire logic              doutValid,
  input  wire logic [DATA_W-1:0] doutData,
  output logic                   doutReady,
  // Register writes to core
  output logic                   taskWr,
  output logic                   cfgWr,
  output logic [DATA_W-1:0]      wrData,
  // Pin outputs
  output logic                   waitN,
  output logic                   dmaRdyN,
  output logic                   dStrobe,
  output logic [DATA_W-1:0]      hostDout,
  output logic                   writeProtect,
  output logic                   is16N
);

  // Two-flop synchronisers for all pin inputs
  localparam int SW = 6 + DATA_W;
  logic [SW-1:0] sync1_r, sync2_r;
  always_ff @(posedge clk) begin
    sync1_r <= {modeSelN, ioConfigured, cycleActiveN, writeStrobeN, hostStrobe,
                regSelN, hostData};
    sync2_r <= sync1_r;
  end
  logic              sModeN, sIoCfg, sCycN, sWeN, sHStrb, sRegN;
  logic [DATA_W-1:0] sData;
  assign {sModeN, sIoCfg, sCycN, sWeN, sHStrb, sRegN, sData} = sync2_r;

  // Mode decode state
  cbf_pkg::cbf_mode_t mode_r, mode_nxt;
  cbf_pkg::cbf_udma_t udma_r, udma_nxt;
  logic [15:0]        initCnt_r, initCnt_nxt;
  logic               initDone_r, initDone_nxt;
  logic               weDly_r;

  always_comb begin
    if (!sModeN) begin
      mode_nxt = cbf_pkg::MODE_IDE;
    end else if (sIoCfg) begin
      mode_nxt = cbf_pkg::MODE_IO;
    end else begin
      mode_nxt = cbf_pkg::MODE_MEM;
    end
    case (1'b1)
      (mode_nxt == cbf_pkg::MODE_IDE) && udmaWrite: udma_nxt = cbf_pkg::UDMA_WRITE;
      (mode_nxt == cbf_pkg::MODE_IDE) && udmaRead:  udma_nxt = cbf_pkg::UDMA_READ;
      default:                                      udma_nxt = cbf_pkg::UDMA_IDLE;
    endcase
    initDone_nxt = initDone_r || (initCnt_r == 16'(INIT_CYCLES - 1));
    initCnt_nxt  = initDone_r ? initCnt_r : initCnt_r + 16'h0001;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      mode_r     <= cbf_pkg::MODE_MEM;
      udma_r     <= cbf_pkg::UDMA_IDLE;
      initCnt_r  <= 16'h0000;
      initDone_r <= 1'b0;
      weDly_r    <= 1'b1;
    end else begin
      mode_r     <= mode_nxt;
      udma_r     <= udma_nxt;
      initCnt_r  <= initCnt_nxt;
      initDone_r <= initDone_nxt;
      weDly_r    <= sWeN;
    end
  end

  // Write-strobe capture per mode
  logic weRise;
  logic taskWr_nxt, cfgWr_nxt;
  assign weRise = sWeN && !weDly_r;
  always_comb begin
    taskWr_nxt = 1'b0;
    cfgWr_nxt  = 1'b0;
    case (mode_r)
      cbf_pkg::MODE_MEM: begin
        taskWr_nxt = weRise && sRegN;
        cfgWr_nxt  = weRise && !sRegN;
      end
      cbf_pkg::MODE_IO: begin
        cfgWr_nxt = weRise && !sRegN;
      end
      cbf_pkg::MODE_IDE: begin
        taskWr_nxt = 1'b0;
      end
      default: begin
        taskWr_nxt = 1'b0;
      end
    endcase
  end

  // Ultra DMA write path through buffer
  logic inReady;
  logic inValid;
  logic hStrbPrev_r;
  // host strobe pushes, write strobe unused
  assign inValid = (udma_r == cbf_pkg::UDMA_WRITE) && (sHStrb != hStrbPrev_r);
  cbf_skid_buf #(.WIDTH(DATA_W), .DEPTH(2)) uBuf (
    .clk      (clk),
    .srst     (srst),
    .inValid  (inValid),
    .inData   (sData),
    .inReady  (inReady),
    .outValid (dinValid),
    .outData  (dinData),
    .outReady (dinReady)
  );

  // Ultra DMA read strobe generator
  logic [3:0]        halfCnt_r, halfCnt_nxt;
  logic              strobe_nxt;
  logic              takeWord;
  logic [DATA_W-1:0] hostDout_nxt;
  always_comb begin
    takeWord     = 1'b0;
    halfCnt_nxt  = halfCnt_r;
    strobe_nxt   = dStrobe;
    hostDout_nxt = hostDout;
    if (udma_r == cbf_pkg::UDMA_READ) begin
      if (halfCnt_r != 4'h0) begin
        halfCnt_nxt = halfCnt_r - 4'h1;
      end else if (doutValid) begin
        takeWord     = 1'b1;
        hostDout_nxt = doutData;
        strobe_nxt   = !dStrobe;
        halfCnt_nxt  = 4'(cbf_pkg::STROBE_HALF_CYC - 1);
      end
    end else begin
      halfCnt_nxt = 4'h0;
      strobe_nxt  = cbf_pkg::STROBE_RST;
    end
  end

  // Pin output next values
  logic waitN_nxt, dmaRdyN_nxt, wp_nxt, is16N_nxt;
  always_comb begin
    waitN_nxt   = 1'b1;
    dmaRdyN_nxt = cbf_pkg::DMARDY_RST;
    wp_nxt      = writeProtect;
    is16N_nxt   = 1'b1;
    case (mode_r)
      cbf_pkg::MODE_MEM, cbf_pkg::MODE_IO: begin
        waitN_nxt = !(!sCycN && !coreReady);
        if (mode_r == cbf_pkg::MODE_MEM && initDone_r) begin
          wp_nxt = 1'b0;
        end
        if (mode_r == cbf_pkg::MODE_IO) begin
          is16N_nxt = !port16;
        end
      end
      cbf_pkg::MODE_IDE: begin
        is16N_nxt = !wordXfer;
        if (udma_r == cbf_pkg::UDMA_IDLE) begin
          waitN_nxt = !(!sCycN && !coreReady);
        end else if (udma_r == cbf_pkg::UDMA_WRITE) begin
          dmaRdyN_nxt = !inReady;
        end
      end
      default: begin
        waitN_nxt = 1'b1;
      end
    endcase
  end

  // Register all outputs except dinValid and dinData, which the buffer registers
  always_ff @(posedge clk) begin
    if (srst) begin
      waitN        <= cbf_pkg::WAIT_RST;
      dmaRdyN      <= cbf_pkg::DMARDY_RST;
      dStrobe      <= cbf_pkg::STROBE_RST;
      hostDout     <= '0;
      writeProtect <= cbf_pkg::WP_RST;
      is16N        <= cbf_pkg::IOIS16_RST;
      halfCnt_r    <= 4'h0;
      doutReady    <= 1'b0;
      taskWr       <= 1'b0;
      cfgWr        <= 1'b0;
      wrData       <= '0;
      hStrbPrev_r  <= 1'b1;
    end else begin
      waitN        <= waitN_nxt;
      dmaRdyN      <= dmaRdyN_nxt;
      dStrobe      <= strobe_nxt;
      hostDout     <= hostDout_nxt;
      writeProtect <= wp_nxt;
      is16N        <= is16N_nxt;
      halfCnt_r    <= halfCnt_nxt;
      doutReady    <= takeWord;
      taskWr       <= taskWr_nxt;
      cfgWr        <= cfgWr_nxt;
      wrData       <= sData;
      hStrbPrev_r  <= sHStrb;
    end
  end

endmodule

// [tb/cbf_flow_chk.sv]
// Pin-level checker for the card bus flow-control block.
// Assumes one clock and the synchronous active-high reset.
module cbf_flow_chk #(
  parameter int DATA_W      = 16,
  parameter int INIT_CYCLES = 4
) (
  // Clock and reset
  input wire logic              clk,
  input wire logic              srst,
  // Pins and core status
  input wire logic              modeSelN,
  input wire logic              ioConfigured,
  input wire logic              coreReady,
  input wire logic              port16,
  input wire logic              wordXfer,
  input wire logic              udmaWrite,
  input wire logic [DATA_W-1:0] doutData,
  // Watched outputs
  input wire logic              doutReady,
  input wire logic              taskWr,
  input wire logic              cfgWr,
  input wire logic              waitN,
  input wire logic              dmaRdyN,
  input wire logic              dStrobe,
  input wire logic [DATA_W-1:0] hostDout,
  input wire logic              writeProtect,
  input wire logic              is16N
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  int memCnt;
  // Consecutive cycles spent in memory mode since reset or the last entry into it, held at 1000
  always_ff @(posedge clk) begin
    if (srst || !modeSelN || ioConfigured) memCnt <= 0;
    else if (memCnt < 1000) memCnt <= memCnt + 1;
  end
  property p_waitRel; coreReady |=> waitN; endproperty
  a_waitRel: assert property (p_waitRel) else $error("hold-off kept");
  property p_waitSet; $fell(waitN) |-> !$past(coreReady); endproperty
  a_waitSet: assert property (p_waitSet) else $error("hold-off unasked");
  property p_wpLow; memCnt > INIT_CYCLES + 8 |-> !writeProtect; endproperty
  a_wpLow: assert property (p_wpLow) else $error("protect high");
  property p_ideNoWr; !modeSelN [*5] |-> !taskWr && !cfgWr; endproperty
  a_ideNoWr: assert property (p_ideNoWr) else $error("write in IDE");
  property p_ioNoTask; (modeSelN && ioConfigured) [*5] |-> !taskWr; endproperty
  a_ioNoTask: assert property (p_ioNoTask) else $error("task write in IO");
  property p_wrPulse; taskWr || cfgWr |=> !taskWr && !cfgWr; endproperty
  a_wrPulse: assert property (p_wrPulse) else $error("write pulse long");
  property p_strbCause; $changed(dStrobe) |-> doutReady; endproperty
  a_strbCause: assert property (p_strbCause) else $error("stray strobe");
  property p_strbGap; $changed(dStrobe) |=> $stable(dStrobe); endproperty
  a_strbGap: assert property (p_strbGap) else $error("strobe too fast");
  property p_strbData; doutReady |-> hostDout == $past(doutData) && $changed(dStrobe); endproperty
  a_strbData: assert property (p_strbData) else $error("word not sent");
  property p_rdyIdle; !udmaWrite [*3] |-> dmaRdyN; endproperty
  a_rdyIdle: assert property (p_rdyIdle) else $error("ready outside");
  property p_is16; !is16N |-> $past(port16) || $past(wordXfer); endproperty
  a_is16: assert property (p_is16) else $error("width low unasked");
  c_task: cover property (taskWr);
  c_pause: cover property (udmaWrite && dmaRdyN);
  c_strobe: cover property ($changed(dStrobe));
endmodule
bind cbf_flow_ctrl cbf_flow_chk #(.DATA_W(DATA_W), .INIT_CYCLES(INIT_CYCLES)) cbf_flow_chk_inst (
  .clk, .srst, .modeSelN, .ioConfigured, .coreReady, .port16, .wordXfer, .udmaWrite,
  .doutData, .doutReady, .taskWr, .cfgWr, .waitN, .dmaRdyN, .dStrobe, .hostDout,
  .writeProtect, .is16N);

// [tb/cbf_host_model.sv]
// Host controller model: drives the write and Ultra DMA strobes, latches read words.
// Assumes the bench pulses toggleReq or hsReq for one clock per strobe edge.
module cbf_host_model (
  // Clock and bench side
  input  wire logic        clk,
  input  wire logic        toggleReq,
  input  wire logic        hsReq,
  output logic [15:0]      gotWord,
  output int               gotCnt,
  // Card pins
  input  wire logic        dStrobe,
  input  wire logic [15:0] hostDout,
  output logic             writeStrobeN,
  output logic             hostStrobe
);
  timeunit 1ns;
  timeprecision 1ps;
  logic lastStrb = 1'b0;
  initial writeStrobeN = 1'b1;
  initial hostStrobe = 1'b1;
  initial gotCnt = 0;
  // Strobe edges on request
  always @(posedge clk) begin
    if (toggleReq) writeStrobeN <= ~writeStrobeN;
    if (hsReq) hostStrobe <= ~hostStrobe;
  end
  always @(posedge clk) begin
    lastStrb <= dStrobe;
    if (dStrobe !== lastStrb) begin
      gotWord <= hostDout;
      gotCnt  <= gotCnt + 1;
    end
  end
endmodule

// [tb/tb_top.sv]
// Self-checking bench for the card bus flow-control block.
// Assumes the host model drives the write strobe pin.
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, srst = 1, modeSelN = 1, ioConfigured = 0, cycleActiveN = 1, regSelN = 1;
  logic coreReady = 0, port16 = 0, wordXfer = 0, udmaWrite = 0, udmaRead = 0;
  logic dinReady = 0, doutValid = 0, toggleReq = 0, hsReq = 0, writeStrobeN, hostStrobe;
  logic [15:0] hostData = '0, doutData = '0, lastWr, gotWord;
  logic dinValid, doutReady, taskWr, cfgWr, waitN, dmaRdyN, dStrobe, writeProtect, is16N;
  logic [15:0] dinData, wrData, hostDout;
  int fails = 0, nCompared = 0, nTask = 0, nCfg = 0, gotCnt;
  always #5 clk = ~clk;
  cbf_flow_ctrl #(.INIT_CYCLES(4)) cbf_flow_ctrl_inst (.clk, .srst, .modeSelN, .ioConfigured,
    .cycleActiveN, .writeStrobeN, .hostStrobe, .regSelN, .hostData, .coreReady, .port16,
    .wordXfer, .udmaWrite, .udmaRead, .dinValid, .dinData, .dinReady, .doutValid, .doutData,
    .doutReady, .taskWr, .cfgWr, .wrData, .waitN, .dmaRdyN, .dStrobe, .hostDout, .writeProtect,
    .is16N);
  cbf_host_model cbf_host_model_inst (.clk, .toggleReq, .hsReq, .gotWord, .gotCnt, .dStrobe,
    .hostDout, .writeStrobeN, .hostStrobe);
  // Register write pulse monitor
  always @(posedge clk) begin
    if (taskWr === 1'b1) nTask++;
    if (cfgWr === 1'b1) nCfg++;
    if (taskWr === 1'b1 || cfgWr === 1'b1) lastWr <= wrData;
  end
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    nCompared++;
    if (g !== e) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic tog(input bit hs = 1'b0);
    if (hs) hsReq = 1;
    else toggleReq = 1;
    cyc(1);
    hsReq = 0;
    toggleReq = 0;
    cyc(4);
  endtask
  task automatic mode(input logic ms, input logic io);
    modeSelN = ms;
    ioConfigured = io;
    cyc(8);
  endtask
  task automatic t_writes();
    int nt, nc;
    for (int m = 0; m < 3; m++) begin
      mode(m != 2, m == 1);
      for (int r = 0; r < 2; r++) begin
        regSelN = r[0];
        hostData = 16'h5a00 + 16'(m * 2 + r);
        nt = nTask;
        nc = nCfg;
        tog();
        tog();
        cyc(2);
        chk("taskWr", m == 0 && r == 1, 16'(nTask - nt));
        chk("cfgWr", m != 2 && r == 0, 16'(nCfg - nc));
        if (m == 0 || (m == 1 && r == 0)) chk("wrData", hostData, lastWr);
      end
    end
  endtask
  task automatic t_wait();
    for (int m = 0; m < 2; m++) begin
      mode(m == 0, 0);
      cycleActiveN = 0;
      cyc(8);
      chk("waitLow", 0, waitN);
      coreReady = 1;
      cyc(2);
      chk("waitRel", 1, waitN);
      cycleActiveN = 1;
      coreReady = 0;
    end
  endtask
  task automatic t_is16();
    mode(1, 1);
    port16 = 1;
    cyc(3);
    chk("is16Io", 0, is16N);
    port16 = 0;
    mode(0, 0);
    wordXfer = 1;
    cyc(3);
    chk("is16Ide", 0, is16N);
    wordXfer = 0;
    cyc(3);
    chk("is16Off", 1, is16N);
  endtask
  task automatic t_udmaW();
    udmaWrite = 1;
    cyc(4);
    chk("rdyOn", 0, dmaRdyN);
    for (int i = 0; i < 2; i++) begin
      hostData = 16'ha000 + 16'(i);
      tog(1'b1);
    end
    cyc(3);
    chk("rdyPause", 1, dmaRdyN);
    dinReady = 1;
    for (int i = 0; i < 2; i++) begin
      chk("dinValid", 1, dinValid);
      chk("dinData", 16'ha000 + 16'(i), dinData);
      cyc(1);
    end
    dinReady = 0;
    cyc(4);
    chk("rdyBack", 0, dmaRdyN);
    udmaWrite = 0;
  endtask
  task automatic t_udmaR();
    int n0;
    logic s;
    n0 = gotCnt;
    udmaRead = 1;
    for (int i = 0; i < 4; i++) begin
      if (i == 2) begin
        doutValid = 0;
        s = dStrobe;
        cyc(6);
        chk("strbPause", s, dStrobe);
      end
      doutValid = 1;
      doutData = 16'h0c30 + 16'(i);
      // Let the previous word's pulse pass first
      cyc(1);
      for (int k = 0; k < 10 && doutReady !== 1'b1; k++) cyc(1);
      chk("doutTaken", 1, doutReady);
    end
    doutValid = 0;
    cyc(3);
    chk("gotCnt", 4, 16'(gotCnt - n0));
    chk("gotWord", 16'h0c33, gotWord);
    udmaRead = 0;
  endtask
  task automatic close_out();
    $display("Compared %0d, mismatched %0d", nCompared, fails);
    if (fails == 0 && nCompared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // Watchdog against a hang
  initial begin
    #20us;
    fails++;
    close_out();
  end
  initial begin
    cyc(3);
    srst = 0;
    chk("wpReset", 1, writeProtect);
    cyc(20);
    chk("wpInit", 0, writeProtect);
    t_writes();
    t_wait();
    t_is16();
    t_udmaW();
    t_udmaR();
    close_out();
  end
endmodule
